// file: acs_assertions.sv
// Purpose: timing checks on the pins between host and converter control
// Assumes: one clock, reset asynchronous and active high
// Notes:   counters hold busy-low and calibration durations
`timescale 1ns/1ps
module acs_assertions #(
   parameter int WAIT_CYC = acs_pkg::POWERUP_WAIT  // settling wait
) (
   input logic       clk,
   input logic       rst,
   input logic       cs_n,
   input logic       rd_n,
   input logic       wr_n,
   input logic       cal_n,
   input logic       upper_byte_select,
   input logic       func_reg_select,
   input logic       busy_n,
   input logic [7:0] dev_d,
   input logic       dev_oe
);
   // ---------------------------------------------
   // helper counters
   // ---------------------------------------------
   logic [16:0] lo_q;   // clocks busy has been low
   logic [8:0]  cc_q;   // clocks since calibration pin rose
   logic        cal_q;  // calibration pending
   logic        up_q;   // power-up sequence done
   // count busy time and calibration time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lo_q  <= '0;
         cc_q  <= '0;
         cal_q <= 1'b0;
         up_q  <= 1'b0;
      end else begin
         lo_q  <= busy_n ? 17'h0 : lo_q + 17'h1;
         cc_q  <= $rose(cal_n) ? 9'h1 : cc_q + {8'h0, cal_q && cc_q != 9'h1ff};
         cal_q <= $rose(cal_n) || (cal_q && !$rose(busy_n));
         up_q  <= up_q || $rose(busy_n);
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_act; !cs_n && !rd_n; endsequence
   sequence rd_hi; (!cs_n && !rd_n && upper_byte_select && !func_reg_select)[*2]; endsequence
   sequence wr_end; (!cs_n && !wr_n) ##1 (cs_n || wr_n); endsequence
   a_bus_drive: assert property (rd_act |=> dev_oe)
      else $error("bus not driven in read");
   a_bus_release: assert property ((cs_n || rd_n) |=> !dev_oe)
      else $error("bus driven outside read");
   a_start_busy: assert property (wr_end |-> ##[1:2] !busy_n)
      else $error("write end did not set busy");
   a_high_zeros: assert property (rd_hi |-> dev_d[6:4] == 3'h0)
      else $error("high byte middle bits not low");
   a_high_status: assert property (rd_hi ##0 ($stable(busy_n) && $past(busy_n, 2) == busy_n)
      |-> dev_d[7] == !busy_n)
      else $error("status bit disagrees with busy");
   a_conv_len: assert property ($rose(busy_n) |-> lo_q >= 17'd17)
      else $error("busy shorter than a conversion");
   a_settle_len: assert property ($rose(busy_n) && !up_q
      |-> lo_q >= WAIT_CYC + 183 && lo_q <= WAIT_CYC + 192)
      else $error("power-up wait length wrong");
   a_cal_hold: assert property (cal_q && cc_q >= 9'd3 && cc_q < 9'd183 |-> !busy_n)
      else $error("busy ended inside calibration");
   a_cal_end: assert property ($rose(busy_n) && cal_q |-> cc_q <= 9'd192)
      else $error("calibration too long");
endmodule

// file: acs_dev.sv
// Purpose: converter control end, sequencing, result bytes and busy
// Assumes: pins synchronous to clk; comparator answers within a clock
// Notes:   analog parts sit outside, reached by the user-side ports
//
// Contract
// (R1) busy low during conversion or calibration
// (R2) latch channel address when write ends
// (R3) address pairs pick channels zero to three
// (R4) conversion starts at write strobe rising edge
// (R5) five sample clocks then twelve decisions
// (R6) calibration on pin rising edge or bit
// (R7) calibration abandons running conversion
// (R8) starts ignored while calibrating
// (R9) 168 calibration clocks then one conversion
// (R10) 42,425 clock wait then auto calibration
// (R11) low byte eight lsbs, high four msbs
// (R12) straight binary, right justified result
// (R13) high byte select switches driven byte live
// (R14) transparent output mode after power up
// (R15) transparent mode writes each decision immediately
// (R16) host trusts result after busy returns
// (R17) high byte: status, zeros, result 11:8
// (R18) latched mode copies result on completion
// (R19) bus released unless select and read low
`timescale 1ns/1ps
module acs_dev #(
   parameter int WAIT_CYC = acs_pkg::POWERUP_WAIT  // settling wait
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pwr_fail,     // supply failure seen
   input  wire logic        comp_hi,      // input above trial code
   output logic [1:0]       ain_sel,      // selected analog input
   output logic             sampling,     // acquisition phase
   output logic [11:0]      trial_code,   // code under test
   acs_if.dev               pins
);
   // ---------------------------------------------
   // sequencer states
   // ---------------------------------------------
   typedef enum logic [4:0] {
      S_WAIT = 5'b00001,   // settling after power up
      S_IDLE = 5'b00010,   // converter idle
      S_CAL  = 5'b00100,   // calibration running
      S_SAMP = 5'b01000,   // sample and auto-zero
      S_CONV = 5'b10000    // bit decisions
   } acs_dst_e;
   acs_dst_e    st_q, st_d;         // sequencer state
   logic [15:0] cnt_q, cnt_d;       // phase counter
   logic [11:0] sar_q, sar_d;       // approximation register
   logic [11:0] res_q, res_d;       // output register
   logic [1:0]  chan_q;             // latched channel
   logic        wr_prev_q;          // write active last cycle
   logic        cal_prev_q;         // cal pin last cycle
   logic        pf_prev_q;          // power fail last cycle
   logic [1:0]  addr_hold_q;        // address during write
   logic [7:0]  wdat_hold_q;        // data during write
   logic        frsel_hold_q;       // register access during write
   logic        mode_q, mode_d;     // latched output mode
   logic        pdn_q, pdn_d;       // power down flag
   logic        pfail_q, pfail_d;   // power fail flag
   // ---------------------------------------------
   // pin decode
   // ---------------------------------------------
   wire wr_act  = ~pins.cs_n & ~pins.wr_n;          // internal write
   wire rd_act  = ~pins.cs_n & ~pins.rd_n;          // internal read
   wire wr_end  = wr_prev_q & ~wr_act;              // rising edge of write
   wire cal_rise = ~cal_prev_q & pins.cal_n;        // end of cal pulse
   wire pf_rise = ~pf_prev_q & pwr_fail;            // new supply failure
   wire fr_wr   = wr_end & frsel_hold_q;            // function register write
   wire cal_req = cal_rise | (fr_wr & wdat_hold_q[acs_pkg::FR_CAL]); // (R6)
   wire busy    = ~st_q[1];                         // any activity
   wire last_cal  = cnt_q == 16'(acs_pkg::CAL_CYC - 1);
   wire last_samp = cnt_q == 16'(acs_pkg::SAMPLE_CYC - 1);
   wire last_dec  = cnt_q == 16'(acs_pkg::DECIDE_CYC - 1);
   wire last_wait = cnt_q == 16'(WAIT_CYC - 1);
   wire [11:0] bit_w = acs_pkg::SAR_MSB >> cnt_q[3:0]; // weight on trial
   wire [11:0] dec_v = comp_hi ? sar_q : (sar_q & ~bit_w); // decided code
   // ---------------------------------------------
   // sequencer next state
   // ---------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 16'h1;
      sar_d = sar_q;
      if (pf_rise) begin
         // supply failure restarts the settling wait
         st_d = S_WAIT;
         cnt_d = 16'h0;
      end else if (cal_req & ~st_q[0]) begin
         st_d = S_CAL;                               // (R7)
         cnt_d = 16'h0;
      end else begin
         case (st_q)
            S_WAIT: if (last_wait) begin
               st_d = S_CAL;                         // (R10)
               cnt_d = 16'h0;
            end
            S_CAL: if (last_cal) begin
               st_d = S_SAMP;                        // (R9)
               cnt_d = 16'h0;
            end
            S_IDLE, S_SAMP, S_CONV: begin
               if (wr_end) begin
                  // a start also restarts a running conversion
                  st_d = S_SAMP;                     // (R4)
                  cnt_d = 16'h0;
               end else if (st_q[3] & last_samp) begin
                  st_d = S_CONV;                     // (R5)
                  cnt_d = 16'h0;
                  sar_d = acs_pkg::SAR_MSB;
               end else if (st_q[4]) begin
                  // keep decision, try next lower weight
                  sar_d = dec_v | (bit_w >> 1);      // (R5)
                  if (last_dec) st_d = S_IDLE;
               end else if (st_q[1]) begin
                  cnt_d = cnt_q;
               end
            end
            default: begin
               st_d = S_WAIT;
               cnt_d = 16'h0;
            end
         endcase
      end
   end
   // ---------------------------------------------
   // output register and function bits
   // ---------------------------------------------
   always_comb begin
      res_d = res_q;
      if (st_q[4] & ~mode_q)
         res_d = (res_q & ~bit_w) | (dec_v & bit_w); // (R15)
      else if (st_q[4] & last_dec & ~pf_rise & ~cal_req)
         res_d = dec_v;                              // (R18)
      mode_d = mode_q;
      pdn_d = pdn_q;
      pfail_d = pfail_q;
      if (fr_wr) begin
         mode_d = wdat_hold_q[acs_pkg::FR_MODE];
         pdn_d = wdat_hold_q[acs_pkg::FR_PDN];
         if (~wdat_hold_q[acs_pkg::FR_PFAIL]) pfail_d = 1'b0;
      end
      if (cal_req) pdn_d = 1'b0;                     // calibration wakes up
      if (pf_rise) begin
         // set wins over clear; settings are lost
         pfail_d = 1'b1;
         mode_d = 1'b0;                              // (R14)
         pdn_d = 1'b0;
      end
   end
   // ---------------------------------------------
   // read data: byte and status selection
   // ---------------------------------------------
   wire [7:0] fr_byte = {busy, 1'b0, pfail_q, 1'b0, pdn_q, 1'b0, st_q[2], mode_q};
   wire [7:0] hi_byte = {busy, 3'h0, res_q[11:8]};  // (R17)
   wire [7:0] rd_byte =
      ~pins.upper_byte_select ? res_q[7:0] :         // (R11)
      (pins.func_reg_select ? fr_byte : hi_byte);    // (R13)
   // ---------------------------------------------
   // state registers
   // ---------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= S_WAIT;
         cnt_q <= 16'h0;
         sar_q <= 12'h0;
         res_q <= 12'h0;
         mode_q <= 1'b0;                             // (R14)
         pdn_q <= 1'b0;
         pfail_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sar_q <= sar_d;
         res_q <= res_d;                             // (R12)
         mode_q <= mode_d;
         pdn_q <= pdn_d;
         pfail_q <= pfail_d;
      end
   end
   // pin edge history and write capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_prev_q <= 1'b0;
         cal_prev_q <= 1'b1;
         pf_prev_q <= 1'b0;
         addr_hold_q <= 2'h0;
         wdat_hold_q <= 8'h0;
         frsel_hold_q <= 1'b0;
         chan_q <= 2'h0;
      end else begin
         wr_prev_q <= wr_act;
         cal_prev_q <= pins.cal_n;
         pf_prev_q <= pwr_fail;
         if (wr_act) begin
            // last value seen before the strobe rises
            addr_hold_q <= {pins.chan_addr_bit1, pins.chan_addr_bit0}; // (R3)
            wdat_hold_q <= pins.data_bus;
            frsel_hold_q <= pins.func_reg_select & pins.upper_byte_select;
         end
         if (wr_end & ~st_q[2] & ~st_q[0]) chan_q <= addr_hold_q; // (R2) (R8)
      end
   end
   // ---------------------------------------------
   // outputs, all from flip-flops
   // ---------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins.busy_n <= 1'b0;
         pins.dev_d <= 8'h0;
         pins.dev_oe <= 1'b0;
         ain_sel <= 2'h0;
         sampling <= 1'b0;
         trial_code <= 12'h0;
      end else begin
         pins.busy_n <= st_d[1];                     // (R1) (R16)
         pins.dev_d <= rd_byte;
         pins.dev_oe <= rd_act;                      // (R19)
         ain_sel <= chan_q;                          // (R3)
         sampling <= st_d[3];                        // (R5)
         trial_code <= sar_d;
      end
   end
endmodule

// file: acs_host.sv
// Purpose: host end, APB registers drive the converter pins
// Assumes: apb slave with no wait states
// Notes:   one operation at a time, commands ignored while active
`timescale 1ns/1ps
module acs_host (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   acs_if.host              pins
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001, H_SET = 4'b0010, H_STRB = 4'b0100, H_HOLD = 4'b1000
   } acs_hst_e;
   acs_hst_e    st_q, st_d;         // phase of current operation
   logic [2:0]  op_q, op_d;         // current operation
   logic [3:0]  cnt_q;              // strobe length counter
   logic [1:0]  chan_q;             // channel to convert
   logic [7:0]  frd_q;              // function register data
   logic [11:0] res_q;              // assembled result
   logic [1:0]  ist_q, ist_d;       // sticky events
   logic [1:0]  mask_q;             // event mask
   logic        busy_prev_q;        // busy pin last cycle
   // ---------------------------------------------
   // bus decode
   // ---------------------------------------------
   wire wr_acc  = psel & penable & pwrite;
   wire ctrl_wr = wr_acc & (paddr == acs_pkg::REG_CTRL) & st_q[0];
   wire strb_end = st_q[2] & (cnt_q == 4'(acs_pkg::STROBE_CYC - 1));
   wire done_ev  = ~busy_prev_q & pins.busy_n;
   wire read_ev  = strb_end & (op_q == acs_pkg::OP_RDHI);
   wire [31:0] rd_mux =
      (paddr == acs_pkg::REG_STAT) ? {26'h0, chan_q, 2'h0, pins.busy_n, ~st_q[0]} :
      (paddr == acs_pkg::REG_RES)  ? {20'h0, res_q} :
      (paddr == acs_pkg::REG_IRQ)  ? {30'h0, ist_q} :
      (paddr == acs_pkg::REG_MASK) ? {30'h0, mask_q} :
      (paddr == acs_pkg::REG_CTRL) ? {16'h0, frd_q, 8'h0} : 32'h0;
   // ---------------------------------------------
   // sequencer next state
   // ---------------------------------------------
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      if (st_q[0] & ctrl_wr) begin
         // priority: cal, read, function write, conversion
         st_d = H_SET;
         if (pwdata[acs_pkg::CT_CAL]) op_d = acs_pkg::OP_CAL;
         else if (pwdata[acs_pkg::CT_READ]) op_d = acs_pkg::OP_RDLO;
         else if (pwdata[acs_pkg::CT_FR]) op_d = acs_pkg::OP_FR;
         else if (pwdata[acs_pkg::CT_CONV]) op_d = acs_pkg::OP_CONV;
         else st_d = H_IDLE;
      end else if (st_q[1]) begin
         st_d = H_STRB;
      end else if (strb_end) begin
         st_d = H_HOLD;
      end else if (st_q[3]) begin
         // low byte read is followed by the high byte
         if (op_q == acs_pkg::OP_RDLO) begin
            st_d = H_SET;
            op_d = acs_pkg::OP_RDHI;
         end else begin
            st_d = H_IDLE;
         end
      end
   end
   // events: set wins over write-one clear
   always_comb begin
      ist_d = ist_q;
      if (wr_acc & (paddr == acs_pkg::REG_IRQ)) ist_d = ist_q & ~pwdata[1:0];
      if (done_ev) ist_d[acs_pkg::IRQ_DONE] = 1'b1;
      if (read_ev) ist_d[acs_pkg::IRQ_READ] = 1'b1;
   end
   // ---------------------------------------------
   // state, registers and apb answer
   // ---------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= H_IDLE; op_q <= acs_pkg::OP_CONV; cnt_q <= 4'h0;
         chan_q <= 2'h0; frd_q <= 8'h0; res_q <= 12'h0;
         ist_q <= 2'h0; mask_q <= 2'h0; busy_prev_q <= 1'b1;
         prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0; irq <= 1'b0;
      end else begin
         st_q <= st_d; op_q <= op_d; ist_q <= ist_d;
         busy_prev_q <= pins.busy_n;
         cnt_q <= st_q[2] ? cnt_q + 4'h1 : 4'h0;
         pready <= psel & ~penable;      // answer one cycle after setup
         if (psel & ~penable) prdata <= rd_mux;
         if (ctrl_wr) begin
            chan_q <= pwdata[5:4];
            frd_q <= pwdata[15:8];
         end
         if (wr_acc & (paddr == acs_pkg::REG_MASK)) mask_q <= pwdata[1:0];
         // sample the bus at the last strobe cycle
         if (strb_end & (op_q == acs_pkg::OP_RDLO)) res_q[7:0] <= pins.data_bus;
         if (read_ev) res_q[11:8] <= pins.data_bus[3:0];
         irq <= |(ist_d & mask_q);
      end
   end
   // ---------------------------------------------
   // pin drivers, set from next phase
   // ---------------------------------------------
   wire s_on = st_d[2];
   wire is_rd = (op_d == acs_pkg::OP_RDLO) | (op_d == acs_pkg::OP_RDHI);
   wire is_wr = (op_d == acs_pkg::OP_CONV) | (op_d == acs_pkg::OP_FR);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins.cs_n <= 1'b1; pins.rd_n <= 1'b1; pins.wr_n <= 1'b1;
         pins.cal_n <= 1'b1; pins.chan_addr_bit0 <= 1'b0;
         pins.chan_addr_bit1 <= 1'b0; pins.upper_byte_select <= 1'b0;
         pins.func_reg_select <= 1'b0; pins.host_d <= 8'h0; pins.host_oe <= 1'b0;
      end else begin
         pins.cs_n <= ~(s_on & (is_rd | is_wr));
         pins.rd_n <= ~(s_on & is_rd);
         pins.wr_n <= ~(s_on & is_wr);
         pins.cal_n <= ~(s_on & (op_d == acs_pkg::OP_CAL)); // (R6)
         pins.chan_addr_bit0 <= chan_q[0];                   // (R3)
         pins.chan_addr_bit1 <= chan_q[1];
         pins.upper_byte_select <= (op_d == acs_pkg::OP_RDHI) | (op_d == acs_pkg::OP_FR);
         pins.func_reg_select <= (op_d == acs_pkg::OP_FR);
         pins.host_d <= frd_q;
         pins.host_oe <= ~st_d[0] & (op_d == acs_pkg::OP_FR);
      end
   end
endmodule

// file: acs_if.sv
// Purpose: parallel pins between host and converter control
// Assumes: all pins synchronous to clk
// Notes:   data bus resolved here from both enables
`timescale 1ns/1ps
interface acs_if;
   logic       cs_n;               // chip select
   logic       rd_n;               // read strobe
   logic       wr_n;               // write strobe
   logic       cal_n;              // calibration pin
   logic       chan_addr_bit0;     // channel address
   logic       chan_addr_bit1;
   logic       upper_byte_select;  // high byte / register select
   logic       func_reg_select;    // function register select
   logic       busy_n;             // converter busy
   logic [7:0] host_d;             // host data out
   logic       host_oe;            // host drives bus
   logic [7:0] dev_d;              // device data out
   logic       dev_oe;             // device drives bus
   wire  [7:0] data_bus;           // resolved bus level
   // undriven bus floats high
   assign data_bus = dev_oe ? dev_d : (host_oe ? host_d : 8'hff);
   modport dev  (input cs_n, rd_n, wr_n, cal_n, chan_addr_bit0, chan_addr_bit1,
                 upper_byte_select, func_reg_select, data_bus,
                 output busy_n, dev_d, dev_oe);
   modport host (output cs_n, rd_n, wr_n, cal_n, chan_addr_bit0, chan_addr_bit1,
                 upper_byte_select, func_reg_select, host_d, host_oe,
                 input busy_n, data_bus);
endinterface

// file: acs_pkg.sv
// Purpose: shared constants of the converter control and its host end
// Assumes: one 20 MHz clock on both ends
// Notes:   strobe count derives from a time in ns, other counts are given in clocks
package acs_pkg;
   // ---------------------------------------------
   // clock and times
   // ---------------------------------------------
   localparam int CLK_NS         = 50;     // period at 20 MHz
   localparam int T_STROBE_NS    = 150;    // strobe low time, covers access
   localparam int STROBE_CYC     = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWERUP_WAIT   = 42425;  // settling wait in clocks
   localparam int CAL_CYC        = 168;    // calibration length
   localparam int SAMPLE_CYC     = 5;      // acquisition and auto-zero
   localparam int DECIDE_CYC     = 12;     // one decision per clock
   // ---------------------------------------------
   // function register bit positions
   // ---------------------------------------------
   localparam int FR_MODE        = 0;      // latched output mode
   localparam int FR_CAL         = 1;      // calibration command/flag
   localparam int FR_PDN         = 3;      // power down
   localparam int FR_PFAIL       = 5;      // power fail flag
   localparam int FR_BUSY        = 7;      // converter status
   localparam logic [11:0] SAR_MSB = 12'h800; // first trial weight
   // ---------------------------------------------
   // host register map (byte addresses)
   // ---------------------------------------------
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_STAT  = 8'h04;
   localparam logic [7:0] REG_RES   = 8'h08;
   localparam logic [7:0] REG_IRQ   = 8'h0c;
   localparam logic [7:0] REG_MASK  = 8'h10;
   localparam int CT_CONV = 0;             // start conversion
   localparam int CT_CAL  = 1;             // calibration pulse
   localparam int CT_READ = 2;             // read both bytes
   localparam int CT_FR   = 3;             // write function register
   localparam int IRQ_DONE = 0;            // busy went high
   localparam int IRQ_READ = 1;            // result read finished
   // host operations
   localparam logic [2:0] OP_CONV = 3'h0;
   localparam logic [2:0] OP_CAL  = 3'h1;
   localparam logic [2:0] OP_RDLO = 3'h2;
   localparam logic [2:0] OP_RDHI = 3'h3;
   localparam logic [2:0] OP_FR   = 3'h4;
endpackage

// file: autocal_adc_sequencer_bench.sv
// Purpose: both ends joined, driven over apb, comparator modelled
// Assumes: host answers pready in the access cycle
// Notes:   short settling wait for simulation
`timescale 1ns/1ps
module autocal_adc_sequencer_bench;
   localparam int W = 50;               // shortened settling wait
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  paddr = 8'h0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq;
   logic        pwr_fail = 1'b0;        // supply failure stimulus
   logic        comp_hi;                // comparator model
   logic [1:0]  ain_sel;
   logic        sampling;
   logic [11:0] trial_code;
   logic [11:0] vin [4] = '{12'h0, 12'h0, 12'h0, 12'h0}; // input per channel
   logic [31:0] seed = 32'ha56a;       // xorshift state
   logic [31:0] q;
   logic [1:0]  msk = 2'h0;            // irq mask as written
   logic [11:0] v;
   int          failures = 0;
   int          n_compared = 0;
   int          cyc = 0;                // free clock count
   int          t0;
   acs_if bus_if ();
   acs_host acs_host_i (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .pins(bus_if.host));
   acs_dev #(.WAIT_CYC(W)) acs_dev_i (.clk(clk), .rst(rst), .pwr_fail(pwr_fail),
      .comp_hi(comp_hi), .ain_sel(ain_sel), .sampling(sampling), .trial_code(trial_code),
      .pins(bus_if.dev));
   acs_assertions #(.WAIT_CYC(W)) acs_assertions_i (.clk(clk), .rst(rst),
      .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .cal_n(bus_if.cal_n),
      .upper_byte_select(bus_if.upper_byte_select), .func_reg_select(bus_if.func_reg_select),
      .busy_n(bus_if.busy_n), .dev_d(bus_if.dev_d), .dev_oe(bus_if.dev_oe));
   // ---------------------------------------------
   // clock, comparator, helpers
   // ---------------------------------------------
   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // input at or above trial code keeps the bit
   assign comp_hi = vin[ain_sel] >= trial_code;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic end_sim;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      psel   <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: no pready", $time);
         end_sim;
      end
      r = prdata;
      chk({31'h0, pslverr}, 32'h0, "pslverr");
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // poll a sticky bit, check irq level, clear it
   task automatic wait_irq(input int b, input int lim);
      logic [31:0] r;
      int n;
      r = '0;
      for (n = 0; n < lim && r[b] !== 1'b1; n++) apb(acs_pkg::REG_IRQ, 1'b0, 32'h0, r);
      if (r[b] !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: event never came", $time);
         end_sim;
      end
      @(posedge clk);
      chk({31'h0, irq}, {31'h0, msk[b]}, "irq raised");
      apb(acs_pkg::REG_IRQ, 1'b1, 32'h1 << b, r);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
   endtask
   task automatic read_res(input logic [11:0] e);
      logic [31:0] r;
      apb(acs_pkg::REG_CTRL, 1'b1, 32'h4, r);
      wait_irq(acs_pkg::IRQ_READ, 40);
      apb(acs_pkg::REG_RES, 1'b0, 32'h0, r);
      chk(r, {20'h0, e}, "result");
   endtask
   task automatic convert(input logic [1:0] ch, input logic [11:0] e, input logic [31:0] c);
      logic [31:0] r;
      vin[ch] <= e;
      apb(acs_pkg::REG_CTRL, 1'b1, c | {26'h0, ch, 4'h0}, r);
      wait_irq(acs_pkg::IRQ_DONE, 60);
      chk({30'h0, ain_sel}, {30'h0, ch}, "channel");
      read_res(e);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t0 = cyc;
      msk = 2'h3;
      apb(acs_pkg::REG_MASK, 1'b1, 32'h3, q);
      wait_irq(acs_pkg::IRQ_DONE, 150);
      chk({31'h0, cyc - t0 >= W + 185}, 32'h1, "settling");
      apb(8'h20, 1'b0, 32'h0, q);
      chk(q, 32'h0, "unmapped");
      // every channel, corners then random codes
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         msk = seed[17:16];
         apb(acs_pkg::REG_MASK, 1'b1, {30'h0, msk}, q);
         v = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : seed[11:0];
         convert(2'(i), v, 32'h1);
      end
      // calibration aborts a conversion, starts ignored meanwhile
      vin[1] <= 12'h5a3;
      apb(acs_pkg::REG_CTRL, 1'b1, 32'h11, q);
      repeat (4) @(posedge clk);
      apb(acs_pkg::REG_CTRL, 1'b1, 32'h2, q);
      repeat (40) @(posedge clk);
      apb(acs_pkg::REG_CTRL, 1'b1, 32'h21, q);
      wait_irq(acs_pkg::IRQ_DONE, 150);
      chk({30'h0, ain_sel}, 32'h1, "channel kept");
      read_res(12'h5a3);
      // latched mode keeps old result during next conversion
      msk = 2'h0;
      apb(acs_pkg::REG_MASK, 1'b1, 32'h0, q);
      convert(2'h0, 12'h3c5, 32'h108);
      vin[0] <= 12'ha5a;
      apb(acs_pkg::REG_CTRL, 1'b1, 32'h1, q);
      repeat (4) @(posedge clk);
      read_res(12'h3c5);
      wait_irq(acs_pkg::IRQ_DONE, 60);
      read_res(12'ha5a);
      // power failure restarts wait and calibration
      t0 = cyc;
      pwr_fail <= 1'b1;
      @(posedge clk);
      pwr_fail <= 1'b0;
      wait_irq(acs_pkg::IRQ_DONE, 150);
      chk({31'h0, cyc - t0 >= W + 185}, 32'h1, "power fail wait");
      convert(2'h3, 12'h7e1, 32'h1);
      apb(acs_pkg::REG_CTRL, 1'b1, 32'h1, q);
      repeat (5) @(posedge clk);
      read_res(12'hae1);
      end_sim;
   end
endmodule
